// [core/iwr_top.sv]
// AXI4-Lite register side of the independent watchdog: key commands,
// write protection, update-pending flags and readback.
// Assumes one AXI4-Lite master; hw_start_option and debug_halt are
// synchronous to aclk.
`timescale 1ns/1ps
module iwr_top
    import iwr_pkg::*;
#(
    parameter int unsigned LSI_CYCLES = LSI_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hw_start_option,
    input wire logic debug_halt,
    output logic watchdog_reset_req
);
    localparam int ACK_WAIT_MAX = 600;

    logic aw_hold_reg, w_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic unlock_reg, unlock_next;
    logic div_pend_reg, div_pend_next;
    logic rel_pend_reg, rel_pend_next;
    logic [DIV_W-1:0] div_data_reg;
    logic [REL_W-1:0] rel_data_reg;
    logic hw_start_reg;

    logic do_write, do_read;
    logic sel_key, sel_div, sel_rel, sel_sts, wr_mapped;
    logic rsel_key, rsel_div, rsel_rel, rsel_sts, rd_mapped;
    logic key_wr;
    logic [KEY_W-1:0] key_val;
    logic div_wr_ok, rel_wr_ok;
    logic start_cmd, reload_cmd;
    logic [31:0] rdata_next;
    logic div_ack, rel_ack, lsi_tick, pre_tick;
    logic [DIV_W-1:0] divider_code;
    logic [REL_W-1:0] reload_count;

    // Write channel: address and data captured in either order
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    assign sel_key = (awaddr_reg == OFF_KEY);
    assign sel_div = (awaddr_reg == OFF_DIV);
    assign sel_rel = (awaddr_reg == OFF_REL);
    assign sel_sts = (awaddr_reg == OFF_STS);
    assign wr_mapped = sel_key || sel_div || sel_rel || sel_sts;

    // Key commands need both low byte lanes
    assign key_val = wdata_reg[KEY_W-1:0];
    assign key_wr = do_write && sel_key && (wstrb_reg[1:0] == 2'h3);
    assign start_cmd = key_wr && (key_val == KEY_START);
    assign reload_cmd = key_wr && (key_val == KEY_RELOAD);
    assign unlock_next = key_wr ? (key_val == KEY_UNLOCK)
                                : unlock_reg;

    assign div_wr_ok = do_write && sel_div && wstrb_reg[0]
                       && unlock_reg && !div_pend_reg;
    assign rel_wr_ok = do_write && sel_rel && (wstrb_reg[1:0] == 2'h3)
                       && unlock_reg && !rel_pend_reg;

    // A fresh write wins over an ack landing in the same cycle
    assign div_pend_next = div_wr_ok
                           || (div_pend_reg && !div_ack);
    assign rel_pend_next = rel_wr_ok
                           || (rel_pend_reg && !rel_ack);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_reg <= 1'b0;
            div_pend_reg <= 1'b0;
            rel_pend_reg <= 1'b0;
            div_data_reg <= DIV_RESET;
            rel_data_reg <= REL_RESET;
            hw_start_reg <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
            div_pend_reg <= div_pend_next;
            rel_pend_reg <= rel_pend_next;
            hw_start_reg <= hw_start_option;
            if (div_wr_ok) begin
                div_data_reg <= wdata_reg[DIV_W-1:0];
            end
            if (rel_wr_ok) begin
                rel_data_reg <= wdata_reg[REL_W-1:0];
            end
        end
    end

    // Read channel: one outstanding read, answered one cycle later
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign do_read = s_axi_arvalid && !rvalid_reg;

    assign rsel_key = (s_axi_araddr == OFF_KEY);
    assign rsel_div = (s_axi_araddr == OFF_DIV);
    assign rsel_rel = (s_axi_araddr == OFF_REL);
    assign rsel_sts = (s_axi_araddr == OFF_STS);
    assign rd_mapped = rsel_key || rsel_div || rsel_rel || rsel_sts;

    // Key reads as zero; reserved bits read as zero
    assign rdata_next =
        rsel_div ? {29'h0, divider_code} :
        rsel_rel ? {20'h0, reload_count} :
        rsel_sts ? {30'h0, rel_pend_reg, div_pend_reg} :
        32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    iwr_prescaler #(
        .LSI_CYCLES(LSI_CYCLES)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .divider_code(divider_code),
        .lsi_tick(lsi_tick),
        .pre_tick(pre_tick)
    );

    iwr_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .lsi_tick(lsi_tick),
        .pre_tick(pre_tick),
        .div_req(div_pend_reg),
        .div_data(div_data_reg),
        .rel_req(rel_pend_reg),
        .rel_data(rel_data_reg),
        .start_cmd(start_cmd),
        .reload_cmd(reload_cmd),
        .hw_start(hw_start_reg),
        .debug_halt(debug_halt),
        .div_ack(div_ack),
        .rel_ack(rel_ack),
        .divider_code(divider_code),
        .reload_count(reload_count),
        .watchdog_reset_req(watchdog_reset_req)
    );

    sequence s_unlock_wr;
        key_wr && key_val == KEY_UNLOCK;
    endsequence
    sequence s_other_key_wr;
        key_wr && key_val != KEY_UNLOCK;
    endsequence

    property p_unlock;
        @(posedge aclk) disable iff (!aresetn)
        s_unlock_wr |=> unlock_reg;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock key did not lift write protection");

    property p_relock;
        @(posedge aclk) disable iff (!aresetn)
        s_other_key_wr |=> !unlock_reg;
    endproperty
    a_relock: assert property (p_relock)
        else $error("other key did not restore write protection");

    property p_div_locked;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && sel_div && !unlock_reg && !div_pend_reg)
            |=> !div_pend_reg && $stable(div_data_reg);
    endproperty
    a_div_locked: assert property (p_div_locked)
        else $error("divider write taken while protected");

    property p_div_busy;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && sel_div && div_pend_reg) |=> $stable(div_data_reg);
    endproperty
    a_div_busy: assert property (p_div_busy)
        else $error("divider changed while update pending");

    property p_rel_busy;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && sel_rel && rel_pend_reg) |=> $stable(rel_data_reg);
    endproperty
    a_rel_busy: assert property (p_rel_busy)
        else $error("reload changed while update pending");

    property p_rel_pend_set;
        @(posedge aclk) disable iff (!aresetn)
        rel_wr_ok |=> rel_pend_reg;
    endproperty
    a_rel_pend_set: assert property (p_rel_pend_set)
        else $error("reload pending flag not set by accepted write");

    property p_rel_pend_clear;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rel_pend_reg) |-> ##[1:ACK_WAIT_MAX] !rel_pend_reg;
    endproperty
    a_rel_pend_clear: assert property (p_rel_pend_clear)
        else $error("reload pending flag never cleared");

    property p_div_readback;
        @(posedge aclk) disable iff (!aresetn)
        (do_read && rsel_div)
            |=> s_axi_rdata == {29'h0, $past(divider_code)};
    endproperty
    a_div_readback: assert property (p_div_readback)
        else $error("divider readback differs from low-speed value");

    property p_rel_readback;
        @(posedge aclk) disable iff (!aresetn)
        (do_read && rsel_rel)
            |=> s_axi_rdata == {20'h0, $past(reload_count)};
    endproperty
    a_rel_readback: assert property (p_rel_readback)
        else $error("reload readback differs from low-speed value");

endmodule : iwr_top

// [core/iwr_pkg.sv]
// Constants, register map and state type of the independent watchdog.
// Assumes a 10 MHz register clock; the low-speed oscillator is an enable.
package iwr_pkg;

    localparam int unsigned CLK_FREQ_HZ = 10_000_000;
    localparam int unsigned LSI_FREQ_HZ = 40_000;
    localparam int unsigned LSI_DIV = CLK_FREQ_HZ / LSI_FREQ_HZ;

    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_KEY = 8'h00;
    localparam logic [7:0] OFF_DIV = 8'h04;
    localparam logic [7:0] OFF_REL = 8'h08;
    localparam logic [7:0] OFF_STS = 8'h0C;

    localparam int unsigned KEY_W = 16;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;
    localparam logic [15:0] KEY_RELOAD = 16'hAAAA;
    localparam logic [15:0] KEY_START = 16'hCCCC;

    localparam int unsigned DIV_W = 3;
    localparam int unsigned REL_W = 12;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [11:0] REL_RESET = 12'hFFF;
    localparam logic [2:0] DIV_CODE_MAX = 3'h5;
    localparam logic [8:0] DIV_BASE = 9'h004;
    localparam int unsigned PRE_W = 8;
    localparam logic [7:0] PRE_LIMIT_MAX = 8'hFF;

    localparam int unsigned STS_DIV_BIT = 0;
    localparam int unsigned STS_REL_BIT = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IWR_IDLE,
        IWR_RUN,
        IWR_FIRED
    } iwr_state_t;

endpackage : iwr_pkg

// [core/iwr_prescaler.sv]
// Low-speed oscillator enable and the selectable prescaler behind it.
// Assumes the divider code comes from the low-speed side value holder.
`timescale 1ns/1ps
module iwr_prescaler
    import iwr_pkg::*;
#(
    parameter int unsigned LSI_CYCLES = LSI_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [DIV_W-1:0] divider_code,
    output logic lsi_tick,
    output logic pre_tick
);
    localparam int unsigned LW = (LSI_CYCLES > 1) ? $clog2(LSI_CYCLES) : 1;
    localparam logic [LW-1:0] LSI_LAST = LW'(LSI_CYCLES - 1);

    logic [LW-1:0] lsi_cnt_reg;
    logic [PRE_W-1:0] pre_cnt_reg;
    logic [8:0] pre_shift;
    logic [PRE_W-1:0] pre_limit;
    logic pre_last;
    logic [PRE_W-1:0] chk_limit;

    assign lsi_tick = (lsi_cnt_reg == LSI_LAST);
    // Divide by 4 << code, codes above the largest by 256
    assign pre_shift = (DIV_BASE << divider_code) - 9'h001;
    assign pre_limit = (divider_code > DIV_CODE_MAX) ? PRE_LIMIT_MAX
                                                     : pre_shift[PRE_W-1:0];
    assign pre_last = (pre_cnt_reg >= pre_limit);
    assign pre_tick = lsi_tick && pre_last;

    // Expected last prescaler count per code, straight from the table
    assign chk_limit = (divider_code == 3'h0) ? 8'h03 :
                       (divider_code == 3'h1) ? 8'h07 :
                       (divider_code == 3'h2) ? 8'h0F :
                       (divider_code == 3'h3) ? 8'h1F :
                       (divider_code == 3'h4) ? 8'h3F :
                       (divider_code == 3'h5) ? 8'h7F : 8'hFF;

    always_ff @(posedge aclk) begin
        if (!aresetn || lsi_tick) begin
            lsi_cnt_reg <= '0;
        end else begin
            lsi_cnt_reg <= lsi_cnt_reg + LW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_reg <= '0;
        end else if (pre_tick) begin
            pre_cnt_reg <= '0;
        end else if (lsi_tick) begin
            pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
    end

    property p_div_period;
        @(posedge aclk) disable iff (!aresetn)
        lsi_tick |-> (pre_tick == (pre_cnt_reg >= chk_limit));
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("prescaler tick does not match the selected ratio");

endmodule : iwr_prescaler

// [core/iwr_core.sv]
// Low-speed side: value holders for divider and reload, and the counter.
// Assumes update requests are levels held until the matching ack pulse.
`timescale 1ns/1ps
module iwr_core
    import iwr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lsi_tick,
    input wire logic pre_tick,
    input wire logic div_req,
    input wire logic [DIV_W-1:0] div_data,
    input wire logic rel_req,
    input wire logic [REL_W-1:0] rel_data,
    input wire logic start_cmd,
    input wire logic reload_cmd,
    input wire logic hw_start,
    input wire logic debug_halt,
    output logic div_ack,
    output logic rel_ack,
    output logic [DIV_W-1:0] divider_code,
    output logic [REL_W-1:0] reload_count,
    output logic watchdog_reset_req
);
    iwr_state_t state_reg, state_next;
    logic [REL_W-1:0] cnt_reg;
    logic div_ack_reg, rel_ack_reg;
    logic running, count_step;

    assign running = (state_reg == IWR_RUN);
    assign count_step = running && pre_tick && !debug_halt;
    assign div_ack = div_ack_reg;
    assign rel_ack = rel_ack_reg;
    assign watchdog_reset_req = (state_reg == IWR_FIRED);

    // New values land only on a low-speed edge, and the ack rises on that same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider_code <= DIV_RESET;
            reload_count <= REL_RESET;
            div_ack_reg <= 1'b0;
            rel_ack_reg <= 1'b0;
        end else begin
            div_ack_reg <= lsi_tick && div_req
                           && !div_ack_reg;
            rel_ack_reg <= lsi_tick && rel_req
                           && !rel_ack_reg;
            if (lsi_tick && div_req && !div_ack_reg) begin
                divider_code <= div_data;
            end
            if (lsi_tick && rel_req && !rel_ack_reg) begin
                reload_count <= rel_data;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IWR_IDLE: begin
                if (start_cmd || hw_start) begin
                    state_next = IWR_RUN;
                end
            end
            IWR_RUN: begin
                if (cnt_reg == '0 && !reload_cmd) begin
                    state_next = IWR_FIRED;
                end
            end
            IWR_FIRED: state_next = IWR_FIRED;
            default: state_next = IWR_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= IWR_IDLE;
            cnt_reg <= REL_RESET;
        end else begin
            state_reg <= state_next;
            if (reload_cmd) begin
                cnt_reg <= reload_count;
            end else if (count_step && cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 12'h001;
            end
        end
    end

    sequence s_armed_zero;
        running && cnt_reg == '0 && !reload_cmd;
    endsequence
    property p_fire;
        @(posedge aclk) disable iff (!aresetn)
        s_armed_zero |=> watchdog_reset_req [*2];
    endproperty
    a_fire: assert property (p_fire)
        else $error("counter at zero did not raise reset request");

    property p_reload;
        @(posedge aclk) disable iff (!aresetn)
        reload_cmd |=> cnt_reg == $past(reload_count);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload command did not load the reload value");

    property p_step;
        @(posedge aclk) disable iff (!aresetn)
        (count_step && !reload_cmd && cnt_reg != '0)
            |=> cnt_reg == $past(cnt_reg) - 12'h001;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not step down on a prescaled tick");

    property p_start;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg == IWR_IDLE && start_cmd) |=> running;
    endproperty
    a_start: assert property (p_start)
        else $error("start command did not start the counter");

endmodule : iwr_core

// [bench/iwr_testbench.sv]
// Self-checking bench for the watchdog register block over AXI4-Lite.
// Assumes iwr_pkg is compiled first; low-speed tick shortened to 32 clocks.
`timescale 1ns/1ps
module testbench;
    import iwr_pkg::*;
    localparam int unsigned LC = 32;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, last_rd;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, hw_start = 1'b0, halt = 1'b0, rst_req;
    logic [1:0] bresp, rresp;
    logic [11:0] rv;
    logic [31:0] bq[$], rq[$];
    logic [31:0] rsq[$];
    int fail_count = 0, n_tests = 0, seed;

    iwr_top #(.LSI_CYCLES(LC)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_start_option(hw_start), .debug_halt(halt),
        .watchdog_reset_req(rst_req));

    always #50 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Scoreboard: oldest expectation against each write response and each read response that has one queued
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            check({30'h0, bresp}, bq.pop_front());
        end
        if (rvalid && rready && rq.size() > 0) begin
            check(rdata, rq.pop_front());
            check({30'h0, rresp}, rsq.pop_front());
        end
    end

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF,
                      input logic [1:0] r = RESP_OKAY);
        logic aw_ok, w_ok;
        @(posedge aclk);
        bq.push_back({30'h0, r});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic q = 1'b1,
                      input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        if (q) begin
            rq.push_back(e);
            rsq.push_back({30'h0, r});
        end
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        last_rd = rdata;
        rready <= 1'b0;
    endtask : rd

    // Polls the pending flags until both are clear
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd(OFF_STS, 32'h0, 1'b0);
            n++;
        end while (last_rd[1:0] !== 2'h0 && n < 200);
        check(last_rd, 32'h0);
    endtask : wait_idle

    task automatic run_code(input int c, input logic hw, input logic slow);
        int n, p;
        logic ok;
        p = (4 << ((c > 6) ? 6 : c)) * LC;
        hw_start <= hw;
        do_reset;
        wr(OFF_KEY, {16'h0, KEY_UNLOCK});
        wait_idle;
        wr(OFF_DIV, 32'(c));
        wr(OFF_REL, 32'h2);
        wait_idle;
        rd(OFF_DIV, 32'(c));
        wr(OFF_KEY, {16'h0, KEY_RELOAD});
        if (slow) begin
            repeat (3 * p) @(posedge aclk);
            check({31'h0, rst_req}, 32'h0);
        end
        if (!hw) wr(OFF_KEY, {16'h0, KEY_START});
        if (slow) begin
            repeat (6) begin
                repeat (p / 2) @(posedge aclk);
                wr(OFF_KEY, {16'h0, KEY_RELOAD});
            end
            halt <= 1'b1;
            repeat (3 * p) @(posedge aclk);
            check({31'h0, rst_req}, 32'h0);
            halt <= 1'b0;
        end
        n = 0;
        while (!rst_req && n < 3 * p) begin
            @(posedge aclk);
            n++;
        end
        ok = (n >= p + 2) && (n <= 2 * p + 1);
        check({31'h0, ok}, 32'h1);
        $display("test divider code %0d hw %0d done", c, hw);
    endtask : run_code

    initial begin
        seed = 32'h5CCA;
        do_reset;
        rd(OFF_KEY, 32'h0);
        rd(OFF_DIV, 32'h0);
        rd(OFF_REL, 32'h0000_0FFF);
        rd(OFF_STS, 32'h0);
        rd(8'h10, 32'h0, 1'b1, RESP_SLVERR);
        wr(8'h10, 32'h1, 4'hF, RESP_SLVERR);
        wr(OFF_DIV, 32'h3);
        wr(OFF_REL, 32'h123);
        rd(OFF_DIV, 32'h0);
        rd(OFF_REL, 32'h0000_0FFF);
        $display("test reset and lock done");
        rv = 12'($random(seed));
        wr(OFF_KEY, {16'h0, KEY_UNLOCK});
        wr(OFF_REL, {20'hFFFFF, rv});
        wait_idle;
        rd(OFF_REL, {20'h0, rv});
        wr(OFF_DIV, 32'h3);
        wr(OFF_DIV, 32'h6);
        rd(OFF_STS, 32'h1);
        rd(OFF_DIV, 32'h0);
        wait_idle;
        rd(OFF_DIV, 32'h3);
        wr(OFF_REL, 32'h0AB);
        wr(OFF_REL, 32'h0CD);
        rd(OFF_STS, 32'h2);
        rd(OFF_REL, {20'h0, rv});
        wait_idle;
        rd(OFF_REL, 32'h0AB);
        $display("test update crossing done");
        wr(OFF_KEY, {16'h0, 16'h1234});
        wr(OFF_REL, 32'h055);
        wr(OFF_KEY, {16'h0, KEY_UNLOCK});
        wr(OFF_KEY, {16'h0, KEY_RELOAD});
        wr(OFF_REL, 32'h055);
        wr(OFF_KEY, {16'h0, KEY_UNLOCK});
        wr(OFF_REL, 32'h055, 4'h1);
        rd(OFF_STS, 32'h0);
        rd(OFF_REL, 32'h0AB);
        $display("test relock done");
        for (int c = 0; c < 8; c++) run_code(c, 1'b0, c == 0);
        run_code(0, 1'b1, 1'b0);
        close_out;
    end

    initial begin
        #(95000 * 100);
        fail_count++;
        close_out;
    end
endmodule : testbench
